// [tb/psd_port2_strap_defaults_bench.sv]
// Self-checking bench for the port 2 strap defaults block
`timescale 1ns/1ps
module psd_port2_strap_defaults_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] strap = 3'h0;
    logic neg_pin, rate_pin, fh_pin;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, dat_o;
    logic ack, f_neg, f_rate, f_fh, f_fd, f_hd;
    logic [2:0] f_mode;
    logic [7:0] e;
    int error_cnt = 0;
    int n_compared = 0;
    wire logic [7:0] fields = {f_neg, f_rate, f_fh, f_fd, f_hd, f_mode};

    always #10 clk = ~clk;

    psd_strap_board psd_strap_board_i
    (
        .setting(strap),
        .neg_pin(neg_pin),
        .rate_pin(rate_pin),
        .fh_pin(fh_pin)
    );

    // One address bit wider than the map, so an unmapped word exists
    psd_port2_strap_defaults #(.ADDR_W(5)) psd_port2_strap_defaults_i
    (
        .clk(clk),
        .reset_n(reset_n),
        .port2_negotiation_pin(neg_pin),
        .port2_rate_default_input(rate_pin),
        .port2_full_half_default_input(fh_pin),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(dat_o),
        .wb_ack_o(ack),
        .basic_ctrl_negotiation_enable_bit(f_neg),
        .basic_ctrl_rate_lsb_bit(f_rate),
        .basic_ctrl_full_half_bit(f_fh),
        .adv_10_full_bit(f_fd),
        .adv_10_half_bit(f_hd),
        .phy_operating_mode_field(f_mode)
    );

    // ==============================
    // Helpers
    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request held until a rising edge samples ack; data is taken and the request dropped at that edge
    task automatic wb_access(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        reset_n <= 1'b0;
        strap <= s;
        repeat (6) @(posedge clk);
        compare({24'h0, fields}, 32'h0, "fields in reset");
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [7:0] dflt(input logic [2:0] s);
        logic n, r, d;
        n = s[2];
        r = s[1];
        d = s[0];
        return {n, r | n, d | n, d & (n | ~r), n | ~r, n ? psd_pkg::MODE_NEG_ALL : {1'b0, r, d}};
    endfunction

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==============================
    // Tests
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            do_reset(i[2:0]);
            e = dflt(i[2:0]);
            compare({24'h0, fields}, {24'h0, e}, "defaults");
            wb_access(1'b0, 5'h0C, 4'hF, 32'h0);
            compare(rdat, {29'h0, i[2:0]}, "strap status");
            wb_access(1'b0, 5'h00, 4'hF, 32'h0);
            compare(rdat, {18'h0, e[6], e[7], 3'h0, e[5], 8'h00}, "basic word");
            wb_access(1'b0, 5'h04, 4'hF, 32'h0);
            compare(rdat, {25'h0, e[4], e[3], 5'h0}, "advert word");
            wb_access(1'b0, 5'h08, 4'hF, 32'h0);
            compare(rdat, {24'h0, e[2:0], 5'h0}, "mode word");
        end
        wb_access(1'b1, 5'h00, 4'hF, 32'h0);
        compare({24'h0, fields}, 32'h1F, "basic overwrite");
        wb_access(1'b1, 5'h04, 4'hE, 32'h0);
        compare({24'h0, fields}, 32'h1F, "advert lane clear");
        wb_access(1'b1, 5'h08, 4'h1, 32'h40);
        compare({24'h0, fields}, 32'h1A, "mode overwrite");
        wb_access(1'b0, 5'h08, 4'hF, 32'h0);
        compare(rdat, 32'h40, "mode readback");
        wb_access(1'b1, 5'h04, 4'h1, 32'h20);
        compare({24'h0, fields}, 32'h0A, "advert overwrite");
        wb_access(1'b1, 5'h0C, 4'hF, 32'h0);
        wb_access(1'b0, 5'h0C, 4'hF, 32'h0);
        compare(rdat, 32'h7, "status read only");
        wb_access(1'b0, 5'h10, 4'hF, 32'h0);
        compare(rdat, 32'h0, "unmapped read");
        // Straps moving after load must not reach the fields
        @(posedge clk);
        strap <= 3'h0;
        repeat (3) @(posedge clk);
        compare({24'h0, fields}, 32'h0A, "straps ignored");
        do_reset(3'h0);
        compare({24'h0, fields}, {24'h0, dflt(3'h0)}, "defaults again");
        summarize();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule

// [tb/psd_strap_board.sv]
// Board-level model of the three port 2 strap pins
`timescale 1ns/1ps
module psd_strap_board
(
    input wire logic [2:0] setting,
    output logic neg_pin,
    output logic rate_pin,
    output logic fh_pin
);
    // Straps are static levels; the bench may move them after load to show they are ignored
    assign neg_pin = setting[2];
    assign rate_pin = setting[1];
    assign fh_pin = setting[0];
endmodule

// [verilog/psd_pkg.sv]
// Constants shared by the port 2 strap defaults block
package psd_pkg;

    // ==============================
    // Register map (byte addresses)
    localparam logic [3:0] OFF_BASIC_CTRL = 4'h0;
    localparam logic [3:0] OFF_NEG_ADVERT = 4'h4;
    localparam logic [3:0] OFF_OP_MODES = 4'h8;
    localparam logic [3:0] OFF_STRAP_STAT = 4'hC;

    // ==============================
    // Field positions
    localparam int BIT_NEG_EN = 12;
    localparam int BIT_RATE_LSB = 13;
    localparam int BIT_FULL_HALF = 8;
    localparam int BIT_ADV_10_FD = 6;
    localparam int BIT_ADV_10_HD = 5;
    localparam int MODE_LSB = 5;
    localparam int MODE_W = 3;
    localparam int STRAP_NEG = 2;
    localparam int STRAP_RATE = 1;
    localparam int STRAP_FH = 0;

    // ==============================
    // Operating mode encodings
    localparam logic [2:0] MODE_NEG_ALL = 3'h7;
    localparam logic MODE_FORCED_MSB = 1'h0;

    // ==============================
    // Values held while reset is asserted
    localparam logic RST_BIT = 1'h0;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// [verilog/psd_port2_strap_defaults.sv]
// Port 2 PHY strap defaults with a Wishbone register view
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - A low negotiation strap makes automatic negotiation default off, a high one makes it default on.
// - The negotiation strap also shapes the rate, duplex, both 10 Mb advertisement and operating mode defaults.
// - The rate strap sets the rate select default: low is 10 Mbps, high is 100 Mbps.
// - The rate strap also shapes both 10 Mb advertisement defaults and the operating mode default.
// - The duplex strap sets the duplex default: low is half duplex, high is full duplex.
// - The duplex strap shapes the 10 Mb full duplex advertisement and mode defaults but not half duplex.
module psd_port2_strap_defaults
#(
    parameter int ADDR_W = 4
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic port2_negotiation_pin,
    input wire logic port2_rate_default_input,
    input wire logic port2_full_half_default_input,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic basic_ctrl_negotiation_enable_bit,
    output logic basic_ctrl_rate_lsb_bit,
    output logic basic_ctrl_full_half_bit,
    output logic adv_10_full_bit,
    output logic adv_10_half_bit,
    output logic [2:0] phy_operating_mode_field
);
    // ==============================
    // State
    logic load_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic neg_en_ff;
    logic rate_ff;
    logic fh_ff;
    logic adv_fd_ff;
    logic adv_hd_ff;
    logic [2:0] mode_ff;
    logic [2:0] strap_ff;

    psd_strap_if sif ();

    // ==============================
    // Strap decode
    assign sif.neg_strap = port2_negotiation_pin;
    assign sif.rate_strap = port2_rate_default_input;
    assign sif.fh_strap = port2_full_half_default_input;

    psd_strap_decode u_decode
    (
        .sif(sif.dec)
    );

    // ==============================
    // Bus decode
    // Requests wait out the load cycle so a write cannot race the defaults
    wire [3:0] adr_lo = 4'(wb_adr_i);
    // Address bits above the map make the access unmapped instead of aliasing a register
    wire adr_in_map = ((wb_adr_i >> 4) == '0);
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff & ~load_ff;
    wire wr = req & wb_we_i;
    wire sel_basic = adr_in_map & (adr_lo == psd_pkg::OFF_BASIC_CTRL);
    wire sel_adv = adr_in_map & (adr_lo == psd_pkg::OFF_NEG_ADVERT);
    wire sel_mode = adr_in_map & (adr_lo == psd_pkg::OFF_OP_MODES);
    wire sel_stat = adr_in_map & (adr_lo == psd_pkg::OFF_STRAP_STAT);
    wire wr_basic = wr & sel_basic & wb_sel_i[1];
    wire wr_adv = wr & sel_adv & wb_sel_i[0];
    wire wr_mode = wr & sel_mode & wb_sel_i[0];

    logic [31:0] word_basic;
    logic [31:0] word_adv;
    logic [31:0] word_mode;
    logic [31:0] word_stat;
    always_comb
    begin
        word_basic = psd_pkg::RST_WORD;
        word_basic[psd_pkg::BIT_NEG_EN] = neg_en_ff;
        word_basic[psd_pkg::BIT_RATE_LSB] = rate_ff;
        word_basic[psd_pkg::BIT_FULL_HALF] = fh_ff;
        word_adv = psd_pkg::RST_WORD;
        word_adv[psd_pkg::BIT_ADV_10_FD] = adv_fd_ff;
        word_adv[psd_pkg::BIT_ADV_10_HD] = adv_hd_ff;
        word_mode = psd_pkg::RST_WORD;
        word_mode[psd_pkg::MODE_LSB +: psd_pkg::MODE_W] = mode_ff;
        word_stat = psd_pkg::RST_WORD;
        word_stat[psd_pkg::STRAP_NEG] = strap_ff[psd_pkg::STRAP_NEG];
        word_stat[psd_pkg::STRAP_RATE] = strap_ff[psd_pkg::STRAP_RATE];
        word_stat[psd_pkg::STRAP_FH] = strap_ff[psd_pkg::STRAP_FH];
    end

    // Unmapped addresses read zero and ignore writes
    wire [31:0] nxt_rdata = sel_basic ? word_basic :
                            sel_adv ? word_adv :
                            sel_mode ? word_mode :
                            sel_stat ? word_stat : psd_pkg::RST_WORD;

    // ==============================
    // Bus answer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= psd_pkg::RST_WORD;
        end
        else
        begin
            ack_ff <= req;
            if (req)
            begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // ==============================
    // Load sequencing
    // Straps are sampled one edge after reset release, never by the reset itself
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            load_ff <= 1'b1;
            strap_ff <= 3'h0;
        end
        else if (load_ff)
        begin
            load_ff <= 1'b0;
            strap_ff <= {port2_negotiation_pin, port2_rate_default_input, port2_full_half_default_input};
        end
    end

    // ==============================
    // Basic control fields
    // defaults at load, software after
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            neg_en_ff <= psd_pkg::RST_BIT;
            rate_ff <= psd_pkg::RST_BIT;
            fh_ff <= psd_pkg::RST_BIT;
        end
        else if (load_ff)
        begin
            neg_en_ff <= sif.dflt_neg_en;
            rate_ff <= sif.dflt_rate_lsb;
            fh_ff <= sif.dflt_full_half;
        end
        else if (wr_basic)
        begin
            neg_en_ff <= wb_dat_i[psd_pkg::BIT_NEG_EN];
            rate_ff <= wb_dat_i[psd_pkg::BIT_RATE_LSB];
            fh_ff <= wb_dat_i[psd_pkg::BIT_FULL_HALF];
        end
    end

    // ==============================
    // Advertisement fields
    // defaults at load, software after
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            adv_fd_ff <= psd_pkg::RST_BIT;
            adv_hd_ff <= psd_pkg::RST_BIT;
        end
        else if (load_ff)
        begin
            adv_fd_ff <= sif.dflt_adv_fd;
            adv_hd_ff <= sif.dflt_adv_hd;
        end
        else if (wr_adv)
        begin
            adv_fd_ff <= wb_dat_i[psd_pkg::BIT_ADV_10_FD];
            adv_hd_ff <= wb_dat_i[psd_pkg::BIT_ADV_10_HD];
        end
    end

    // ==============================
    // Operating mode field
    // defaults at load, software after
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mode_ff <= psd_pkg::RST_MODE;
        end
        else if (load_ff)
        begin
            mode_ff <= sif.dflt_mode;
        end
        else if (wr_mode)
        begin
            mode_ff <= wb_dat_i[psd_pkg::MODE_LSB +: psd_pkg::MODE_W];
        end
    end

    // ==============================
    // Outputs
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign basic_ctrl_negotiation_enable_bit = neg_en_ff;
    assign basic_ctrl_rate_lsb_bit = rate_ff;
    assign basic_ctrl_full_half_bit = fh_ff;
    assign adv_10_full_bit = adv_fd_ff;
    assign adv_10_half_bit = adv_hd_ff;
    assign phy_operating_mode_field = mode_ff;

    // ==============================
    // Checks
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_neg_enable_default: assert property (
        load_ff |=> neg_en_ff == $past(port2_negotiation_pin))
        else $error("negotiation enable default does not follow strap");

    chk_neg_forces_all: assert property (
        load_ff && port2_negotiation_pin |=> rate_ff && fh_ff && adv_hd_ff && mode_ff == psd_pkg::MODE_NEG_ALL)
        else $error("negotiation strap did not force capable defaults");

    chk_rate_default: assert property (
        load_ff && !port2_negotiation_pin |=> rate_ff == $past(port2_rate_default_input))
        else $error("rate default does not follow strap");

    chk_rate_advert: assert property (
        load_ff && !port2_negotiation_pin |=> adv_hd_ff == !$past(port2_rate_default_input)
            && mode_ff[1] == $past(port2_rate_default_input))
        else $error("rate strap not reflected in advertisement or mode");

    chk_duplex_default: assert property (
        load_ff && !port2_negotiation_pin |=> fh_ff == $past(port2_full_half_default_input))
        else $error("duplex default does not follow strap");

    chk_duplex_fd_only: assert property (
        load_ff && !port2_rate_default_input |=> adv_hd_ff
            && adv_fd_ff == $past(port2_full_half_default_input))
        else $error("duplex strap misapplied to advertisement");

    chk_write_overrides: assert property (
        wr_basic |=> neg_en_ff == $past(wb_dat_i[psd_pkg::BIT_NEG_EN]) ##1 $stable(neg_en_ff))
        else $error("software write to basic control not kept");

    chk_straps_ignored: assert property (
        !load_ff && !wr_basic && !wr_mode |=> $stable(neg_en_ff) && $stable(mode_ff))
        else $error("field changed without load or write");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_adv_write_kept: assert property (
        wr_adv |=> adv_fd_ff == $past(wb_dat_i[psd_pkg::BIT_ADV_10_FD])
            && adv_hd_ff == $past(wb_dat_i[psd_pkg::BIT_ADV_10_HD]))
        else $error("software write to advertisement not kept");

    chk_mode_write_kept: assert property (
        wr_mode |=> mode_ff == $past(wb_dat_i[psd_pkg::MODE_LSB +: psd_pkg::MODE_W]))
        else $error("software write to operating mode not kept");

    chk_hd_ignores_duplex: assert property (
        load_ff |=> adv_hd_ff == ($past(port2_negotiation_pin) || !$past(port2_rate_default_input)))
        else $error("duplex strap reached half duplex advertisement");

    chk_fd_under_neg: assert property (
        load_ff && port2_negotiation_pin |=> adv_fd_ff == $past(port2_full_half_default_input))
        else $error("duplex strap not reflected in full duplex advertisement");

    chk_status_latched: assert property (
        load_ff |=> strap_ff[psd_pkg::STRAP_NEG] == $past(port2_negotiation_pin)
            && strap_ff[psd_pkg::STRAP_RATE] == $past(port2_rate_default_input)
            && strap_ff[psd_pkg::STRAP_FH] == $past(port2_full_half_default_input))
        else $error("strap status does not hold the sampled straps");

    chk_ack_after_req: assert property (
        req |=> wb_ack_o)
        else $error("taken request not acknowledged next cycle");

    chk_no_take_in_load: assert property (
        load_ff |=> !wb_ack_o)
        else $error("request taken during the load cycle");

    chk_unmapped_zero: assert property (
        req && !wb_we_i && !sel_basic && !sel_adv && !sel_mode && !sel_stat |=> wb_dat_o == psd_pkg::RST_WORD)
        else $error("unmapped address did not read zero");

    cov_neg_on: cover property (load_ff && port2_negotiation_pin);
    cov_forced_100_full: cover property (load_ff && !port2_negotiation_pin
        && port2_rate_default_input && port2_full_half_default_input);
    cov_sw_override: cover property (wr_basic ##1 wb_ack_o);
    cov_unmapped_read: cover property (req && !wb_we_i && !sel_basic && !sel_adv && !sel_mode && !sel_stat);
    cov_adv_override: cover property (wr_adv ##1 wb_ack_o);
endmodule

// [verilog/psd_strap_decode.sv]
// Combinational decode of the three port 2 straps into field defaults
`timescale 1ns/1ps
module psd_strap_decode
(
    psd_strap_if.dec sif
);
    // ==============================
    // Decode
    // negotiation enable default
    assign sif.dflt_neg_en = sif.neg_strap;

    // rate default, forced high by negotiation
    assign sif.dflt_rate_lsb = sif.rate_strap | sif.neg_strap;

    // duplex default, forced full by negotiation
    assign sif.dflt_full_half = sif.fh_strap | sif.neg_strap;

    // 10 Mb full duplex advertised only if duplex allows it
    assign sif.dflt_adv_fd = sif.fh_strap & (sif.neg_strap | ~sif.rate_strap);

    // 10 Mb half duplex advertised unless forced to 100 Mbps
    assign sif.dflt_adv_hd = sif.neg_strap | ~sif.rate_strap;

    // operating mode: all capable, or forced rate and duplex
    assign sif.dflt_mode = sif.neg_strap ? psd_pkg::MODE_NEG_ALL
                                         : {psd_pkg::MODE_FORCED_MSB, sif.rate_strap, sif.fh_strap};
endmodule

// [verilog/psd_strap_if.sv]
// Carrier between the strap decoder and the register block
`timescale 1ns/1ps
interface psd_strap_if;
    logic neg_strap;
    logic rate_strap;
    logic fh_strap;
    logic dflt_neg_en;
    logic dflt_rate_lsb;
    logic dflt_full_half;
    logic dflt_adv_fd;
    logic dflt_adv_hd;
    logic [2:0] dflt_mode;

    modport dec
    (
        input neg_strap,
        input rate_strap,
        input fh_strap,
        output dflt_neg_en,
        output dflt_rate_lsb,
        output dflt_full_half,
        output dflt_adv_fd,
        output dflt_adv_hd,
        output dflt_mode
    );

    modport top
    (
        output neg_strap,
        output rate_strap,
        output fh_strap,
        input dflt_neg_en,
        input dflt_rate_lsb,
        input dflt_full_half,
        input dflt_adv_fd,
        input dflt_adv_hd,
        input dflt_mode
    );
endinterface
